// ---- rfcd_clk_div.sv ----
// CPU clock divider: one-cycle enable per divided period
module rfcd_clk_div (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic [2:0] i_code,
  input wire logic i_apply,
  output logic o_tick,
  output logic [2:0] o_code
);

  logic [6:0] cnt_q;
  logic [2:0] code_q;
  logic [2:0] pend_code_q;
  logic pend_q;
  logic [6:0] limit;

  // Terminal count halves with each code step
  assign limit = rfcd_pkg::DIV_MAX_LIMIT >> code_q;
  assign o_tick = (cnt_q == limit);
  assign o_code = code_q;

  // Pending code waits for the next period end, so no runt period
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 7'h00;
      code_q <= rfcd_pkg::DIV_CODE_RST;
      pend_code_q <= rfcd_pkg::DIV_CODE_RST;
      pend_q <= 1'b0;
    end else begin
      if (i_apply) begin
        pend_q <= 1'b1;
        pend_code_q <= i_code;
      end else if (o_tick && pend_q) begin
        pend_q <= 1'b0;
      end
      if (o_tick) begin
        cnt_q <= 7'h00;
        if (pend_q) begin
          code_q <= pend_code_q;
        end
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

endmodule : rfcd_clk_div

// ---- rfcd_cpu_model.sv ----
// CPU core stand-in: times the clock enable and issues program fetches
module rfcd_cpu_model (
  input wire logic i_clk_sys,
  input wire logic i_cpu_en,
  input wire logic i_fetch_ready,
  input wire logic i_go,
  input wire logic i_clr,
  output logic o_fetch_req = 1'b0,
  output int o_ticks = 0,
  output int o_period = 0,
  output int o_min_period = 1000,
  output int o_fetch_len = 0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cyc = 0;
  int last = 0;

  // Enable spacing in system cycles; clearing restarts the minimum
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
    if (i_clr) begin
      o_min_period <= 1000;
    end else if (i_cpu_en === 1'b1 && cyc - last < o_min_period) begin
      o_min_period <= cyc - last;
    end
    if (i_cpu_en === 1'b1) begin
      o_ticks <= o_ticks + 1;
      o_period <= cyc - last;
      last <= cyc;
    end
  end

  // One fetch per go, held until answered, never dropped early
  always @(posedge i_clk_sys) begin
    if (o_fetch_req && i_cpu_en === 1'b1) begin
      o_fetch_len <= o_fetch_len + 1;
    end
    if (o_fetch_req && i_fetch_ready === 1'b1) begin
      o_fetch_req <= 1'b0;
    end else if (i_go && !o_fetch_req) begin
      o_fetch_req <= 1'b1;
      o_fetch_len <= 0;
    end
  end
endmodule : rfcd_cpu_model

// ---- rfcd_fetch_wait.sv ----
// Program-memory fetch stretcher counting CPU clock enables
module rfcd_fetch_wait (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  input wire logic i_cpu_en,
  input wire logic i_req,
  input wire logic [2:0] i_stretch,
  output logic o_ready
);

  logic [2:0] cnt_q;

  // Fetch ends on the CPU clock that completes stretch+1 clocks
  assign o_ready = i_req && i_cpu_en && (cnt_q == i_stretch);

  // Counter restarts after each finished fetch
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      cnt_q <= 3'h0;
    end else if (i_req && i_cpu_en) begin
      cnt_q <= o_ready ? 3'h0 : cnt_q + 3'h1;
    end
  end

endmodule : rfcd_fetch_wait

// ---- rfcd_pkg.sv ----
// Package: register map, field layout and keys of the reset/clock block
// Operation
// - After each reset the cause flag is set: bit 7 supply, bit 6 watchdog, bit 5 pin.
// - Bit 2 shows supply below the mid level and bit 1 below the high level, read-only.
// - A software reset starts only after two successive writes of one to bit 0.
// - Writing the key 0x5A to the watchdog clear register clears the watchdog.
// - The clock source selection is caught after each reset and never changes until the next reset.
// - Divider code 000 divides by 128, each higher code halves it, 111 divides by 1.
// - A newly written divider code takes effect only after 0x69 goes to the command key.
// - Fetch stretch code 000 takes one CPU clock per fetch and code 111 takes eight.
// - A program-memory interface between CPU and memory lengthens fetch cycles.
// - Halt gates only the CPU clock; peripherals keep running.
// - Stop disables all functions and the clock generator until a wake-up.
// - Power control bit 0 requests halt, bit 1 stop, and the bit clears on wake-up.
// - Halt wakes on a port level change or interrupt, stop only on a port change.
package rfcd_pkg;

  // ---------------------------------------------------------------
  // Bus and register map (index; byte address is four times index)
  // ---------------------------------------------------------------
  localparam int ADDR_W = 12;
  localparam logic [7:0] IDX_WDT_KEY = 8'h86;
  localparam logic [7:0] IDX_FETCH = 8'h8E;
  localparam logic [7:0] IDX_FLAGS = 8'h90;
  localparam logic [7:0] IDX_SOFTWARE_RESET_REQUEST = 8'h91;
  localparam logic [7:0] IDX_DIV = 8'h92;
  localparam logic [7:0] IDX_CLK_CMD = 8'h93;
  localparam logic [7:0] IDX_PWR = 8'h94;
  localparam logic [7:0] IDX_IRQ_STAT = 8'h95;
  localparam logic [7:0] IDX_IRQ_MASK = 8'h96;
  localparam logic [7:0] IDX_CLK_SRC = 8'h97;
  localparam logic [11:0] ADDR_WDT_KEY = {2'h0, IDX_WDT_KEY, 2'h0};
  localparam logic [11:0] ADDR_FETCH = {2'h0, IDX_FETCH, 2'h0};
  localparam logic [11:0] ADDR_FLAGS = {2'h0, IDX_FLAGS, 2'h0};
  localparam logic [11:0] ADDR_SOFTWARE_RESET_REQUEST = {2'h0, IDX_SOFTWARE_RESET_REQUEST, 2'h0};
  localparam logic [11:0] ADDR_DIV = {2'h0, IDX_DIV, 2'h0};
  localparam logic [11:0] ADDR_CLK_CMD = {2'h0, IDX_CLK_CMD, 2'h0};
  localparam logic [11:0] ADDR_PWR = {2'h0, IDX_PWR, 2'h0};
  localparam logic [11:0] ADDR_IRQ_STAT = {2'h0, IDX_IRQ_STAT, 2'h0};
  localparam logic [11:0] ADDR_IRQ_MASK = {2'h0, IDX_IRQ_MASK, 2'h0};
  localparam logic [11:0] ADDR_CLK_SRC = {2'h0, IDX_CLK_SRC, 2'h0};

  // ---------------------------------------------------------------
  // Keys, fields and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] KEY_WDT_CLEAR = 8'h5A;
  localparam logic [7:0] KEY_CLK_APPLY = 8'h69;
  localparam int FLAG_SUPPLY = 7;
  localparam int FLAG_WDT = 6;
  localparam int FLAG_PIN = 5;
  localparam int FLAG_MID = 2;
  localparam int FLAG_HIGH = 1;
  localparam int SOFTWARE_RESET_REQUEST_BIT = 0;
  localparam int PWR_HALT = 0;
  localparam int PWR_STOP = 1;
  localparam int FETCH_LSB = 4;
  localparam logic [2:0] DIV_CODE_RST = 3'h0;
  localparam logic [2:0] FETCH_CODE_RST = 3'h7;
  localparam logic [6:0] DIV_MAX_LIMIT = 7'h7F;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  // ---------------------------------------------------------------
  // Interrupt events (status and mask share this layout)
  // ---------------------------------------------------------------
  localparam int EV_W = 4;
  localparam int EV_SOFTWARE_RESET_REQUEST = 0;
  localparam int EV_WDT = 1;
  localparam int EV_WAKE = 2;
  localparam int EV_CLK = 3;

endpackage : rfcd_pkg

// ---- rfcd_top.sv ----
// Reset flags, software reset, watchdog key and CPU clock control
//
// Local design decision: the AHB-Lite register port.
module rfcd_top (
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // AHB-Lite slave
  input wire logic i_hsel,
  input wire logic [11:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic o_hreadyout,
  output logic o_hresp,
  output logic [31:0] o_hrdata,
  // Reset causes, supply levels and clock source strap
  input wire logic i_cause_supply,
  input wire logic i_cause_watchdog,
  input wire logic i_cause_pin,
  input wire logic i_supply_below_mid,
  input wire logic i_supply_below_high,
  input wire logic [2:0] i_clk_source_strap,
  // Wake-up sources and fetch request
  input wire logic i_port_change,
  input wire logic i_irq_any,
  input wire logic i_fetch_req,
  // Outputs to the rest of the chip
  output logic o_soft_reset,
  output logic o_watchdog_clear,
  output logic o_cpu_clk_en,
  output logic o_fetch_ready,
  output logic o_osc_enable,
  output logic o_halt,
  output logic o_stop,
  output logic [2:0] o_clk_source,
  output logic o_irq
);

  // ---------------------------------------------------------------
  // Reset release
  // ---------------------------------------------------------------
  logic rst_meta_q;
  logic rst_b;

  // Assert asynchronously, release after two clean edges
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rst_meta_q <= 1'b0;
      rst_b <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_b <= rst_meta_q;
    end
  end

  // ---------------------------------------------------------------
  // Bus address phase and decode
  // ---------------------------------------------------------------
  logic ap_valid;
  logic ap_read;
  logic dp_wr_q;
  logic [11:0] dp_addr_q;
  logic wr_wdt;
  logic wr_fetch;
  logic wr_software_reset_request;
  logic wr_div;
  logic wr_cmd;
  logic wr_pwr;
  logic wr_mask;
  logic rd_stat;
  logic [7:0] wbyte;

  // Transfer taken when selected, NONSEQ and bus ready
  assign ap_valid = i_hsel && i_hready &&
                    (i_htrans == rfcd_pkg::HTRANS_NONSEQ);
  assign ap_read = ap_valid && !i_hwrite;
  assign wbyte = i_hwdata[7:0];

  // Writes commit in the data phase, when hwdata stands
  assign wr_wdt = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_WDT_KEY);
  assign wr_fetch = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_FETCH);
  assign wr_software_reset_request = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST);
  assign wr_div = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_DIV);
  assign wr_cmd = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_CLK_CMD);
  assign wr_pwr = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_PWR);
  assign wr_mask = dp_wr_q && (dp_addr_q == rfcd_pkg::ADDR_IRQ_MASK);
  assign rd_stat = ap_read && (i_haddr == rfcd_pkg::ADDR_IRQ_STAT);

  // Never stalls; every answer is OKAY
  assign o_hreadyout = 1'b1;
  assign o_hresp = 1'b0;

  // Data-phase pipeline register
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 12'h000;
    end else begin
      dp_wr_q <= ap_valid && i_hwrite;
      dp_addr_q <= i_haddr;
    end
  end

  // ---------------------------------------------------------------
  // Reset causes and clock source, caught once after release
  // ---------------------------------------------------------------
  logic cap_done_q;
  logic [2:0] cause_q;
  logic [2:0] clk_src_q;

  // Caught by the clock, not by the reset, so no port feeds a reset
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cap_done_q <= 1'b0;
      cause_q <= 3'h0;
      clk_src_q <= 3'h0;
    end else if (!cap_done_q) begin
      cap_done_q <= 1'b1;
      cause_q <= {i_cause_supply, i_cause_watchdog, i_cause_pin};
      clk_src_q <= i_clk_source_strap;
    end
  end
  assign o_clk_source = clk_src_q;

  // ---------------------------------------------------------------
  // Software reset and watchdog key
  // ---------------------------------------------------------------
  logic software_reset_request_armed_q;
  logic software_reset_request_fire;
  logic soft_reset_q;
  logic wdt_clear_q;
  logic wdt_hit;

  assign software_reset_request_fire = wr_software_reset_request && wbyte[rfcd_pkg::SOFTWARE_RESET_REQUEST_BIT] && software_reset_request_armed_q;
  assign wdt_hit = wr_wdt && (wbyte == rfcd_pkg::KEY_WDT_CLEAR);

  // First write of one arms; a second one fires, a zero disarms
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      software_reset_request_armed_q <= 1'b0;
      soft_reset_q <= 1'b0;
      wdt_clear_q <= 1'b0;
    end else begin
      if (wr_software_reset_request) begin
        software_reset_request_armed_q <= wbyte[rfcd_pkg::SOFTWARE_RESET_REQUEST_BIT] && !software_reset_request_armed_q;
      end
      soft_reset_q <= software_reset_request_fire;
      wdt_clear_q <= wdt_hit;
    end
  end
  assign o_soft_reset = soft_reset_q;
  assign o_watchdog_clear = wdt_clear_q;

  // ---------------------------------------------------------------
  // CPU clock divider and fetch stretch
  // ---------------------------------------------------------------
  logic [2:0] div_code_q;
  logic [2:0] fetch_code_q;
  logic clk_apply;
  logic cpu_tick;
  logic [2:0] act_code;
  logic cpu_en;

  // Divider code only reaches the divider on the command key
  assign clk_apply = wr_cmd && (wbyte == rfcd_pkg::KEY_CLK_APPLY);

  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      div_code_q <= rfcd_pkg::DIV_CODE_RST;
      fetch_code_q <= rfcd_pkg::FETCH_CODE_RST;
    end else begin
      if (wr_div) begin
        div_code_q <= wbyte[2:0];
      end
      if (wr_fetch) begin
        fetch_code_q <= wbyte[rfcd_pkg::FETCH_LSB +: 3];
      end
    end
  end

  rfcd_clk_div u_div (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(rst_b),
    .i_code(div_code_q),
    .i_apply(clk_apply),
    .o_tick(cpu_tick),
    .o_code(act_code)
  );

  // ---------------------------------------------------------------
  // Power states
  // ---------------------------------------------------------------
  logic halt_q;
  logic stop_q;
  logic wake_halt;
  logic wake_stop;

  // Halt gates only the CPU enable; stop also drops the oscillator
  assign cpu_en = cpu_tick && !halt_q && !stop_q;
  assign wake_halt = halt_q && (i_port_change || i_irq_any);
  assign wake_stop = stop_q && i_port_change;

  // A write in the wake cycle wins, so a fresh request is kept
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      halt_q <= 1'b0;
      stop_q <= 1'b0;
    end else if (wr_pwr) begin
      halt_q <= wbyte[rfcd_pkg::PWR_HALT];
      stop_q <= wbyte[rfcd_pkg::PWR_STOP];
    end else begin
      if (wake_halt) begin
        halt_q <= 1'b0;
      end
      if (wake_stop) begin
        stop_q <= 1'b0;
      end
    end
  end
  assign o_halt = halt_q;
  assign o_stop = stop_q;
  assign o_osc_enable = !stop_q;
  assign o_cpu_clk_en = cpu_en;

  rfcd_fetch_wait u_fetch (
    .i_clk_sys(i_clk_sys),
    .i_rst_b(rst_b),
    .i_cpu_en(cpu_en),
    .i_req(i_fetch_req),
    .i_stretch(fetch_code_q),
    .o_ready(o_fetch_ready)
  );

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  logic [rfcd_pkg::EV_W-1:0] events;
  logic [rfcd_pkg::EV_W-1:0] stat_q;
  logic [rfcd_pkg::EV_W-1:0] mask_q;
  logic [rfcd_pkg::EV_W-1:0] stat_keep;

  assign events = {clk_apply, wake_halt || wake_stop, wdt_hit, software_reset_request_fire};
  assign stat_keep = rd_stat ? '0 : stat_q;

  // Read clears, but an event in that same cycle is kept
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      stat_q <= '0;
      mask_q <= '0;
    end else begin
      stat_q <= stat_keep | events;
      if (wr_mask) begin
        mask_q <= wbyte[rfcd_pkg::EV_W-1:0];
      end
    end
  end
  assign o_irq = |(stat_q & mask_q);

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [7:0] rd_mux;
  logic [7:0] flags_rd;

  // Supply flags are live levels; causes are the caught copy
  assign flags_rd = {cause_q, 2'h0, i_supply_below_mid,
                     i_supply_below_high, 1'b0};
  assign rd_mux =
    (i_haddr == rfcd_pkg::ADDR_FLAGS) ? flags_rd :
    (i_haddr == rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST) ? {7'h00, software_reset_request_armed_q} :
    (i_haddr == rfcd_pkg::ADDR_FETCH) ? {1'b0, fetch_code_q, 4'h0} :
    (i_haddr == rfcd_pkg::ADDR_DIV) ? {5'h00, div_code_q} :
    (i_haddr == rfcd_pkg::ADDR_PWR) ? {6'h00, stop_q, halt_q} :
    (i_haddr == rfcd_pkg::ADDR_IRQ_STAT) ? {4'h0, stat_q} :
    (i_haddr == rfcd_pkg::ADDR_IRQ_MASK) ? {4'h0, mask_q} :
    (i_haddr == rfcd_pkg::ADDR_CLK_SRC) ? {5'h00, clk_src_q} : 8'h00;

  // Sampled in the address phase; write-only and unmapped read zero
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      o_hrdata <= 32'h0000_0000;
    end else if (ap_read) begin
      o_hrdata <= {24'h00_0000, rd_mux};
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  logic cmd_seen_q;

  // Remembers a key write until the divider takes the new code
  always_ff @(posedge i_clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_seen_q <= 1'b0;
    end else if (clk_apply) begin
      cmd_seen_q <= 1'b1;
    end else if (cpu_tick) begin
      cmd_seen_q <= 1'b0;
    end
  end

  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!rst_b);

  property p_cause_caught;
    $rose(cap_done_q) |-> flags_rd[7:5] ==
      $past({i_cause_supply, i_cause_watchdog, i_cause_pin});
  endproperty
  a_cause_caught: assert property (p_cause_caught)
    else $error("reset cause not caught");

  property p_soft_twice;
    wr_software_reset_request && wbyte[rfcd_pkg::SOFTWARE_RESET_REQUEST_BIT] && software_reset_request_armed_q |=>
      o_soft_reset ##1 !o_soft_reset;
  endproperty
  a_soft_twice: assert property (p_soft_twice)
    else $error("second write did not fire soft reset");

  property p_soft_cause;
    o_soft_reset |-> $past(software_reset_request_armed_q) && $past(wr_software_reset_request);
  endproperty
  a_soft_cause: assert property (p_soft_cause)
    else $error("soft reset without two writes");

  property p_wdt_key;
    wr_wdt |=>
      (o_watchdog_clear == ($past(wbyte) == rfcd_pkg::KEY_WDT_CLEAR));
  endproperty
  a_wdt_key: assert property (p_wdt_key)
    else $error("watchdog clear not tied to key");

  property p_div_by_one;
    act_code == 3'h7 && !halt_q && !stop_q |-> o_cpu_clk_en;
  endproperty
  a_div_by_one: assert property (p_div_by_one)
    else $error("code 111 must enable every cycle");

  // The code in force after a tick decides, so a switch away is not flagged
  property p_div_128;
    cpu_tick ##1 (act_code == 3'h0) |-> !cpu_tick [*8];
  endproperty
  a_div_128: assert property (p_div_128)
    else $error("divide by 128 too short");

  property p_code_after_key;
    act_code != $past(act_code) |-> $past(cmd_seen_q) && $past(cpu_tick);
  endproperty
  a_code_after_key: assert property (p_code_after_key)
    else $error("divider changed without key or off boundary");

  property p_halt_gates;
    halt_q || stop_q |-> !o_cpu_clk_en && !o_fetch_ready;
  endproperty
  a_halt_gates: assert property (p_halt_gates)
    else $error("CPU clock runs while halted");

  property p_stop_osc;
    stop_q |-> !o_osc_enable;
  endproperty
  a_stop_osc: assert property (p_stop_osc)
    else $error("oscillator runs in stop");

  property p_wake;
    halt_q && !stop_q && i_irq_any && !wr_pwr |=> !halt_q;
  endproperty
  a_wake: assert property (p_wake)
    else $error("halt did not wake on interrupt");

  property p_stop_no_irq;
    stop_q && i_irq_any && !i_port_change && !wr_pwr |=> stop_q;
  endproperty
  a_stop_no_irq: assert property (p_stop_no_irq)
    else $error("stop woke on interrupt");

  property p_fetch_one;
    fetch_code_q == 3'h0 && i_fetch_req && o_cpu_clk_en |-> o_fetch_ready;
  endproperty
  a_fetch_one: assert property (p_fetch_one)
    else $error("stretch 000 must take one CPU clock");

  property p_irq_level;
    o_irq |-> |(stat_q & mask_q);
  endproperty
  a_irq_level: assert property (p_irq_level)
    else $error("interrupt without unmasked status");

  c_soft: cover property (o_soft_reset);
  c_stop_wake: cover property (stop_q ##1 !stop_q);
  c_code: cover property (act_code != $past(act_code));
  c_fetch8: cover property (fetch_code_q == 3'h7 && o_fetch_ready);

endmodule : rfcd_top

// ---- tb_top.sv ----
// Self-checking bench for the reset flag and CPU clock control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk_sys = 1'b0;
  logic i_rst_b = 1'b0;
  logic i_hsel = 1'b0;
  logic [11:0] i_haddr = 12'h000;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [31:0] i_hwdata = 32'h0;
  logic i_cause_supply = 1'b1;
  logic i_cause_watchdog = 1'b0;
  logic i_cause_pin = 1'b1;
  logic i_supply_below_mid = 1'b1;
  logic i_supply_below_high = 1'b1;
  logic [2:0] i_clk_source_strap = 3'h5;
  logic i_port_change = 1'b0;
  logic i_irq_any = 1'b0;
  logic go = 1'b0;
  logic clr = 1'b0;
  logic i_fetch_req, o_hreadyout, o_hresp, o_soft_reset, o_watchdog_clear;
  logic o_cpu_clk_en, o_fetch_ready, o_osc_enable, o_halt, o_stop, o_irq;
  logic [31:0] o_hrdata;
  logic [2:0] o_clk_source;
  int n_fail = 0;
  int samples_checked = 0;
  int n_software_reset_request = 0;
  int n_wdc = 0;
  int ticks, period, min_period, fetch_len;

  always #10 i_clk_sys = ~i_clk_sys;

  // Size is tied to word; hready is the one slave's answer
  rfcd_top u_dut (
    .i_clk_sys, .i_rst_b, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize(3'h2), .i_hwdata, .i_hready(o_hreadyout), .o_hreadyout,
    .o_hresp, .o_hrdata, .i_cause_supply, .i_cause_watchdog, .i_cause_pin,
    .i_supply_below_mid, .i_supply_below_high, .i_clk_source_strap,
    .i_port_change, .i_irq_any, .i_fetch_req, .o_soft_reset,
    .o_watchdog_clear, .o_cpu_clk_en, .o_fetch_ready, .o_osc_enable,
    .o_halt, .o_stop, .o_clk_source, .o_irq
  );
  rfcd_cpu_model u_cpu (
    .i_clk_sys, .i_cpu_en(o_cpu_clk_en), .i_fetch_ready(o_fetch_ready),
    .i_go(go), .i_clr(clr), .o_fetch_req(i_fetch_req), .o_ticks(ticks),
    .o_period(period), .o_min_period(min_period), .o_fetch_len(fetch_len)
  );

  // Pulse counters: a stuck or doubled pulse shows as a wrong count
  always @(posedge i_clk_sys) begin
    if (o_soft_reset === 1'b1) n_software_reset_request++;
    if (o_watchdog_clear === 1'b1) n_wdc++;
  end

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic conclude;
    if (n_fail == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  task automatic give_up(input bit hung);
    if (hung) begin
      n_fail++;
      conclude();
    end
  endtask : give_up

  task automatic chk(input string n, input logic [31:0] s, e);
    samples_checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  task automatic edge_rdy;
    int k = 0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (o_hreadyout !== 1'b1 && k < 100);
    give_up(o_hreadyout !== 1'b1);
  endtask : edge_rdy

  // One single transfer; read data is taken at the end of the data phase
  task automatic bus(input logic w, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    i_hsel <= 1'b1;
    i_haddr <= a;
    i_htrans <= rfcd_pkg::HTRANS_NONSEQ;
    i_hwrite <= w;
    edge_rdy();
    i_htrans <= 2'h0;
    i_hwdata <= d;
    edge_rdy();
    r = o_hrdata;
    chk("hresp", 32'(o_hresp), 32'h0);
    chk("hready", 32'(o_hreadyout), 32'h1);
  endtask : bus

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rc(input string n, input logic [11:0] a,
                    input logic [31:0] e);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(n, r, e);
  endtask : rc

  task automatic wait_ticks(input int n);
    int t0;
    int k = 0;
    clr <= 1'b1;
    @(posedge i_clk_sys);
    clr <= 1'b0;
    t0 = ticks;
    while (ticks - t0 < n && k < 2000) begin
      @(posedge i_clk_sys);
      k++;
    end
    give_up(k >= 2000);
  endtask : wait_ticks

  task automatic fetch(input int s);
    int k = 0;
    go <= 1'b1;
    @(posedge i_clk_sys);
    go <= 1'b0;
    do begin
      @(posedge i_clk_sys);
      k++;
    end while (i_fetch_req !== 1'b0 && k < 500);
    give_up(k >= 500);
    chk("fetch_len", fetch_len, s + 1);
  endtask : fetch

  // Wake source pulse: port change when p is set, else interrupt
  task automatic kick(input bit p);
    if (p) i_port_change <= 1'b1;
    else i_irq_any <= 1'b1;
    @(posedge i_clk_sys);
    i_port_change <= 1'b0;
    i_irq_any <= 1'b0;
    repeat (3) @(posedge i_clk_sys);
  endtask : kick

  task automatic do_reset;
    i_rst_b <= 1'b0;
    repeat (10) @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    repeat (4) @(posedge i_clk_sys);
  endtask : do_reset

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int t;
    do_reset();
    rc("software_reset_request", rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h0);
    rc("div", rfcd_pkg::ADDR_DIV, 32'h0);
    rc("fetch", rfcd_pkg::ADDR_FETCH, 32'h70);
    rc("mask", rfcd_pkg::ADDR_IRQ_MASK, 32'h0);
    rc("flags", rfcd_pkg::ADDR_FLAGS, 32'hA6);
    wr(12'h100, 32'hFF);
    rc("unmapped", 12'h100, 32'h0);
    // Causes and strap move after capture; only live levels may follow
    i_cause_supply <= 1'b0;
    i_cause_pin <= 1'b0;
    i_supply_below_mid <= 1'b0;
    i_clk_source_strap <= 3'h2;
    wr(rfcd_pkg::ADDR_FLAGS, 32'h0);
    wr(rfcd_pkg::ADDR_CLK_SRC, 32'h7);
    rc("flags_live", rfcd_pkg::ADDR_FLAGS, 32'hA2);
    rc("clk_src", rfcd_pkg::ADDR_CLK_SRC, 32'h5);
    chk("clk_src_out", 32'(o_clk_source), 32'h5);
    // A code without the key, or with a wrong key, leaves the rate alone
    wr(rfcd_pkg::ADDR_DIV, 32'h7);
    wr(rfcd_pkg::ADDR_CLK_CMD, 32'h68);
    wait_ticks(2);
    chk("held_period", period, 128);
    for (int c = 0; c < 8; c++) begin
      wr(rfcd_pkg::ADDR_DIV, 32'(c));
      wr(rfcd_pkg::ADDR_CLK_CMD, 32'(rfcd_pkg::KEY_CLK_APPLY));
      wait_ticks(3);
      chk("period", period, 128 >> c);
      chk("min_period", min_period, 128 >> c);
    end
    // Divide by 8 keeps fetches at 6.25 MHz or less for every stretch
    wr(rfcd_pkg::ADDR_DIV, 32'h4);
    wr(rfcd_pkg::ADDR_CLK_CMD, 32'(rfcd_pkg::KEY_CLK_APPLY));
    wait_ticks(2);
    for (int s = 0; s < 8; s++) begin
      wr(rfcd_pkg::ADDR_FETCH, 32'(s << rfcd_pkg::FETCH_LSB));
      fetch(s);
    end
    rc("irq_clk", rfcd_pkg::ADDR_IRQ_STAT, 32'h8);
    // Halt freezes the CPU enable only; an interrupt ends it
    wr(rfcd_pkg::ADDR_PWR, 32'h1);
    @(posedge i_clk_sys);
    t = ticks;
    chk("halt", 32'(o_halt), 32'h1);
    repeat (40) @(posedge i_clk_sys);
    chk("halt_ticks", ticks, t);
    chk("osc_halt", 32'(o_osc_enable), 32'h1);
    kick(1'b0);
    chk("halt_wake", 32'(o_halt), 32'h0);
    rc("pwr_halt", rfcd_pkg::ADDR_PWR, 32'h0);
    // Stop ignores interrupts and leaves only on a port change
    wr(rfcd_pkg::ADDR_PWR, 32'h2);
    @(posedge i_clk_sys);
    t = ticks;
    chk("osc_stop", 32'(o_osc_enable), 32'h0);
    kick(1'b0);
    chk("stop_irq", 32'(o_stop), 32'h1);
    chk("stop_ticks", ticks, t);
    kick(1'b1);
    chk("stop_wake", 32'(o_stop), 32'h0);
    rc("pwr_stop", rfcd_pkg::ADDR_PWR, 32'h0);
    // Arm, disarm, then fire across a write elsewhere
    wr(rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h1);
    rc("software_reset_request_arm", rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h1);
    wr(rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h0);
    rc("software_reset_request_off", rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h0);
    wr(rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h1);
    wr(rfcd_pkg::ADDR_IRQ_MASK, 32'h0);
    wr(rfcd_pkg::ADDR_SOFTWARE_RESET_REQUEST, 32'h1);
    wr(rfcd_pkg::ADDR_WDT_KEY, 32'h5B);
    wr(rfcd_pkg::ADDR_WDT_KEY, 32'hA5);
    chk("wdt_other", n_wdc, 0);
    wr(rfcd_pkg::ADDR_WDT_KEY, 32'(rfcd_pkg::KEY_WDT_CLEAR));
    repeat (2) @(posedge i_clk_sys);
    chk("wdt_key", n_wdc, 1);
    chk("software_reset_request_fire", n_software_reset_request, 1);
    chk("irq_masked", 32'(o_irq), 32'h0);
    wr(rfcd_pkg::ADDR_IRQ_MASK, 32'h2);
    repeat (2) @(posedge i_clk_sys);
    chk("irq_on", 32'(o_irq), 32'h1);
    rc("irq_stat", rfcd_pkg::ADDR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge i_clk_sys);
    chk("irq_off", 32'(o_irq), 32'h0);
    rc("irq_clr", rfcd_pkg::ADDR_IRQ_STAT, 32'h0);
    // A second reset with a new cause and strap
    i_cause_watchdog <= 1'b1;
    do_reset();
    rc("flags_wdt", rfcd_pkg::ADDR_FLAGS, 32'h42);
    rc("clk_src_new", rfcd_pkg::ADDR_CLK_SRC, 32'h2);
    conclude();
  end
endmodule : tb_top
